/* pkg/eoi_pkg.sv */
// eoi_pkg: constants and types of the e3 overhead insertion port.
// assumes one overhead bit period spans eight link clock cycles.
package eoi_pkg;

	// overhead positions per frame and their counter
	localparam int POS_W = 6;
	localparam logic [5:0] POS_FIRST = 6'h00;
	localparam logic [5:0] POS_FIRST_INS = 6'h18;
	localparam logic [5:0] POS_LAST = 6'h37;
	localparam int OVH_BITS = 56;

	// link cycles inside one overhead bit period
	localparam logic [2:0] PHASE_FIRST = 3'h0;
	localparam logic [2:0] PHASE_HALF = 3'h4;
	localparam logic [2:0] PHASE_LAST = 3'h7;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam int BYTE_BITS = 8;

	// reset values
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [1:0] PIN_RESET = 2'h0;

	// buffering of assembled overhead bytes
	localparam int FIFO_DEPTH = 32;
	localparam int WORD_W = 19;

	// one assembled overhead byte, msb first as sent
	typedef struct packed {
		logic [2:0] byte_idx;
		logic [7:0] data;
		logic [7:0] ins_mask;
	} eoi_ovh_word_type;

	typedef enum logic [1:0] {
		LS_HOLD = 2'b01,
		LS_RUN = 2'b10
	} eoi_line_state_type;

endpackage

/* verilog/eoi_fifo.sv */
// eoi_fifo: synchronous first-in first-out buffer with valid/ready.
// assumes both sides on one clock; output shows the oldest word.
`timescale 1ns/1ps
module eoi_fifo #(
	parameter int WIDTH = eoi_pkg::WORD_W,
	parameter int DEPTH = eoi_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// filling side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// draining side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic [AW:0] next_wr_ptr;
	logic [AW:0] next_rd_ptr;
	logic full;
	logic empty;
	logic do_wr;
	logic do_rd;

	// pointer arithmetic, extra msb tells full from empty
	always_comb
	begin
		full = (wr_ptr[AW] != rd_ptr[AW]) &&
			(wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
		empty = (wr_ptr == rd_ptr);
		do_wr = in_valid_i && !full;
		do_rd = out_ready_i && !empty;
		next_wr_ptr = do_wr ? wr_ptr + {{AW{1'b0}}, 1'b1} : wr_ptr;
		next_rd_ptr = do_rd ? rd_ptr + {{AW{1'b0}}, 1'b1} : rd_ptr;
	end

	// pointers
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	// storage, no reset needed
	always_ff @(posedge clk_i)
	begin
		if (do_wr)
			mem[wr_ptr[AW-1:0]] <= in_data_i;
	end

	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem[rd_ptr[AW-1:0]];

endmodule

/* verilog/eoi_tx_ovh_port.sv */
// eoi_tx_ovh_port: transmit overhead insertion port, bit clock method.
// assumes the link clock runs freely; system side drains assembled bytes.
//
// Function
// R1 - partner samples the frame boundary on every bit clock rising edge.
// R2 - partner counts bit clock rising edges since boundary was seen high.
// R3 - at the wanted count partner raises insert enable and drives data.
// R4 - count zero is the rise seeing boundary high: first framing byte msb.
// R5 - positions 0 to 23 keep the framer's own bits, never overwritten.
// R6 - positions 24 to 29 take inserted values, trail trace bits 7..2; the code accepts inserted values at every position from 24 to 55.
// R7 - bytes go msb first, eight edges each, in fixed order.
// R8 - data sampled near falling edge only while insert enable is high.
// R9 - frame boundary pulses high while the frame's last bit is processed.
// R10 - a bit clock rise precedes every overhead bit, insertable or not.
// R11 - insertion attempts at non-insertable positions are silently dropped.
// R12 - partner counter restarts at zero on boundary, else counts up.
`timescale 1ns/1ps
module eoi_tx_ovh_port #(
	parameter logic [55:0] DEFAULT_OVH = 56'h0,
	parameter int FIFO_DEPTH = eoi_pkg::FIFO_DEPTH
) (
	// system clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// link clock
	input wire logic ovh_line_clk_i,
	// overhead insertion pins
	output logic ovh_bit_clock_o,
	output logic ovh_frame_boundary_o,
	input wire logic ovh_insert_enable_i,
	input wire logic ovh_data_in_i,
	// assembled overhead bytes toward the system
	output eoi_pkg::eoi_ovh_word_type ovh_word_o,
	output logic ovh_word_valid_o,
	input wire logic ovh_word_ready_i,
	// status
	output logic ovh_overrun_o
);
	// link domain state
	eoi_pkg::eoi_line_state_type state;
	eoi_pkg::eoi_line_state_type next_state;
	logic [2:0] phase;
	logic [2:0] next_phase;
	logic [5:0] pos;
	logic [5:0] next_pos;
	logic bit_clk;
	logic next_bit_clk;
	logic boundary;
	logic next_boundary;
	logic [7:0] shift;
	logic [7:0] next_shift;
	logic [7:0] mask;
	logic [7:0] next_mask;
	eoi_pkg::eoi_ovh_word_type hold;
	eoi_pkg::eoi_ovh_word_type next_hold;
	logic req;
	logic next_req;
	logic overrun;
	logic next_overrun;
	logic [1:0] pin_s1;
	logic [1:0] pin_s2;
	logic [1:0] pin_s3;
	logic [1:0] pin_f;
	logic [1:0] next_pin_f;
	logic ack_s1;
	logic ack_s2;
	logic ack_s3;
	logic ack_f;
	logic next_ack_f;
	logic take;
	logic busy;
	logic cur_ok;
	logic cur_bit;
	logic [2:0] pos_byte;
	// system domain state
	logic req_s1;
	logic req_s2;
	logic req_s3;
	logic ack;
	logic next_ack;
	logic push;
	logic fifo_in_ready;
	logic [eoi_pkg::WORD_W-1:0] fifo_out;
	logic fifo_valid;
	logic fifo_take;
	eoi_pkg::eoi_ovh_word_type word;
	eoi_pkg::eoi_ovh_word_type next_word;
	logic word_valid;
	logic next_word_valid;

	// position accepts an external value only when enabled and late enough
	function automatic logic ins_ok(input logic [5:0] p, input logic en);
		ins_ok = en && (p >= eoi_pkg::POS_FIRST_INS);
	endfunction

	// link domain next values
	always_comb
	begin
		next_state = state;
		next_phase = phase + 3'h1;
		next_pos = pos;
		next_shift = shift;
		next_mask = mask;
		next_hold = hold;
		next_req = req;
		next_overrun = overrun;
		take = (state == eoi_pkg::LS_RUN) && (phase == eoi_pkg::PHASE_LAST);
		busy = (req != ack_f);
		pos_byte = pos[5:3];
		cur_ok = ins_ok(pos, pin_f[1]); // R5 R6 R11
		cur_bit = cur_ok ? pin_f[0] :
			DEFAULT_OVH[eoi_pkg::POS_LAST - pos]; // R8
		// stable pin levels only once the last two stages agree
		next_pin_f = (pin_s2 & ~(pin_s2 ^ pin_s3)) |
			(pin_f & (pin_s2 ^ pin_s3));
		next_ack_f = (ack_s2 == ack_s3) ? ack_s3 : ack_f;
		case (state)
			eoi_pkg::LS_HOLD:
			begin
				if (phase == eoi_pkg::PHASE_LAST)
					next_state = eoi_pkg::LS_RUN;
			end
			eoi_pkg::LS_RUN:
			begin
				if (take)
				begin
					// each bit period advances one overhead position
					next_pos = (pos == eoi_pkg::POS_LAST) ?
						eoi_pkg::POS_FIRST : pos + 6'h01; // R10
					next_shift = {shift[6:0], cur_bit}; // R7
					next_mask = {mask[6:0], cur_ok};
					if (pos[2:0] == eoi_pkg::BIT_LAST)
					begin
						if (busy)
							next_overrun = 1'b1;
						else
						begin
							next_hold.byte_idx = pos_byte; // R7
							next_hold.data = {shift[6:0], cur_bit};
							next_hold.ins_mask = {mask[6:0], cur_ok};
							next_req = ~req;
						end
					end
				end
			end
			default:
			begin
				next_state = eoi_pkg::LS_HOLD;
			end
		endcase
		// bit clock high in the first half of each bit period
		next_bit_clk = (next_state == eoi_pkg::LS_RUN) &&
			(next_phase < eoi_pkg::PHASE_HALF); // R10
		// boundary spans the last bit's second half and the first rise
		next_boundary = (next_state == eoi_pkg::LS_RUN) &&
			(((next_pos == eoi_pkg::POS_LAST) &&
			(next_phase >= eoi_pkg::PHASE_HALF)) ||
			((next_pos == eoi_pkg::POS_FIRST) &&
			(next_phase < eoi_pkg::PHASE_HALF))); // R9 R4
	end

	// link domain registers
	always_ff @(posedge ovh_line_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state <= eoi_pkg::LS_HOLD;
			phase <= eoi_pkg::PHASE_FIRST;
			pos <= eoi_pkg::POS_LAST;
			bit_clk <= 1'b0;
			boundary <= 1'b0;
			shift <= eoi_pkg::BYTE_RESET;
			mask <= eoi_pkg::BYTE_RESET;
			hold <= '0;
			req <= 1'b0;
			overrun <= 1'b0;
			pin_s1 <= eoi_pkg::PIN_RESET;
			pin_s2 <= eoi_pkg::PIN_RESET;
			pin_s3 <= eoi_pkg::PIN_RESET;
			pin_f <= eoi_pkg::PIN_RESET;
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
			ack_s3 <= 1'b0;
			ack_f <= 1'b0;
		end
		else
		begin
			state <= next_state;
			phase <= next_phase;
			pos <= next_pos;
			bit_clk <= next_bit_clk;
			boundary <= next_boundary;
			shift <= next_shift;
			mask <= next_mask;
			hold <= next_hold;
			req <= next_req;
			overrun <= next_overrun;
			pin_s1 <= {ovh_insert_enable_i, ovh_data_in_i};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f <= next_pin_f;
			ack_s1 <= ack;
			ack_s2 <= ack_s1;
			ack_s3 <= ack_s2;
			ack_f <= next_ack_f;
		end
	end

	// system domain: take a held byte once the request toggle settles
	always_comb
	begin
		push = (req_s2 == req_s3) && (req_s3 != ack) && fifo_in_ready;
		next_ack = push ? ~ack : ack;
		// output stage refills when empty or drained, so pins come from flops
		fifo_take = !word_valid || ovh_word_ready_i;
		next_word = word;
		next_word_valid = word_valid;
		if (fifo_take)
		begin
			next_word = eoi_pkg::eoi_ovh_word_type'(fifo_out);
			next_word_valid = fifo_valid;
		end
	end

	// system domain registers
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
			ack <= 1'b0;
			word <= '0;
			word_valid <= 1'b0;
		end
		else
		begin
			req_s1 <= req;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
			ack <= next_ack;
			word <= next_word;
			word_valid <= next_word_valid;
		end
	end

	// byte buffer; a full buffer holds the handshake, then overrun shows
	eoi_fifo #(
		.WIDTH(eoi_pkg::WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.in_valid_i(push),
		.in_ready_o(fifo_in_ready),
		.in_data_i(hold),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_take),
		.out_data_o(fifo_out)
	);

	assign ovh_word_o = word;
	assign ovh_word_valid_o = word_valid;
	assign ovh_bit_clock_o = bit_clk;
	assign ovh_frame_boundary_o = boundary;
	assign ovh_overrun_o = overrun;

	// sequences for the link side checks
	sequence seq_rise;
		$rose(bit_clk);
	endsequence

	sequence seq_boundary_hold;
		boundary [*8] ##1 !boundary;
	endsequence

	AST_BOUNDARY_AT_ZERO: assert property ( // R4
		@(posedge ovh_line_clk_i) disable iff (!nrst_i)
		seq_rise ##0 boundary |-> pos == eoi_pkg::POS_FIRST)
		else $error("boundary seen at a rise other than position zero");

	AST_KEEP_OWN_BITS: assert property ( // R5
		@(posedge ovh_line_clk_i) disable iff (!nrst_i)
		take && (pos < eoi_pkg::POS_FIRST_INS) |=>
		shift[0] == DEFAULT_OVH[eoi_pkg::POS_LAST - $past(pos)])
		else $error("protected overhead bit was changed");

	AST_INSERT_ACCEPTED: assert property ( // R6
		@(posedge ovh_line_clk_i) disable iff (!nrst_i)
		take && (pos >= eoi_pkg::POS_FIRST_INS) && pin_f[1] |=>
		mask[0] && (shift[0] == $past(pin_f[0])))
		else $error("insertable bit did not take the pin value");

	AST_BYTE_ORDER: assert property ( // R7
		@(posedge ovh_line_clk_i) disable iff (!nrst_i)
		take && (pos[2:0] == eoi_pkg::BIT_LAST) && !busy |=>
		(req != $past(req)) && (hold.byte_idx == $past(pos_byte)) &&
		(hold.data == shift))
		else $error("assembled byte out of order");

	AST_ENABLE_LOW_IGNORED: assert property ( // R8
		@(posedge ovh_line_clk_i) disable iff (!nrst_i)
		take && !pin_f[1] |=> !mask[0])
		else $error("data taken while insert enable was low");

	AST_BOUNDARY_WIDTH: assert property ( // R9
		@(posedge ovh_line_clk_i) disable iff (!nrst_i)
		$rose(boundary) |-> (pos == eoi_pkg::POS_LAST) ##0
		seq_boundary_hold)
		else $error("frame boundary pulse has wrong place or width");

	AST_RISE_EVERY_BIT: assert property ( // R10
		@(posedge ovh_line_clk_i) disable iff (!nrst_i)
		seq_rise |-> ##8 $rose(bit_clk))
		else $error("bit clock rise missing for an overhead bit");

	AST_POS_ON_RISE: assert property ( // R10
		@(posedge ovh_line_clk_i) disable iff (!nrst_i)
		$changed(pos) |-> $rose(bit_clk))
		else $error("position moved without a bit clock rise");

	AST_DISCARD_EARLY: assert property ( // R11
		@(posedge ovh_line_clk_i) disable iff (!nrst_i)
		take && pin_f[1] && (pos < eoi_pkg::POS_FIRST_INS) |=> !mask[0])
		else $error("insertion accepted at a protected position");

endmodule

/* verification/eoi_term_model.sv */
// eoi_term_model: terminal side that overwrites chosen overhead bits.
// assumes the framer's bit clock and boundary; plan bit 55 is position 0.
`timescale 1ns/1ps
module eoi_term_model (
	// framer pins
	input wire logic bit_clk_i,
	input wire logic boundary_i,
	output logic ins_en_o,
	output logic ins_data_o,
	// insertion plan
	input wire logic [55:0] mask_i,
	input wire logic [55:0] val_i,
	// position tracking
	output logic [5:0] cnt_o,
	output logic [5:0] len_o,
	output logic synced_o
);
	// idle until the first boundary is seen
	initial
	begin
		ins_en_o = 1'b0;
		ins_data_o = 1'b0;
		cnt_o = 6'h00;
		len_o = 6'h37;
		synced_o = 1'b0;
	end
	// count rises since the boundary, then drive the planned bit
	always @(posedge bit_clk_i)
	begin
		if (boundary_i)
		begin
			if (synced_o)
				len_o = cnt_o;
			cnt_o = 6'h00;
			synced_o = 1'b1;
		end
		else
			cnt_o = cnt_o + 6'h01;
		// hold pins to the next rise; released data toggles
		if (synced_o && mask_i[6'h37 - cnt_o])
		begin
			ins_en_o = 1'b1;
			ins_data_o = val_i[6'h37 - cnt_o];
		end
		else
		begin
			ins_en_o = 1'b0;
			ins_data_o = ~ins_data_o;
		end
	end
endmodule

/* verification/e3_tx_overhead_insert_port_tb.sv */
// e3_tx_overhead_insert_port_tb: self-checking bench of the insert port.
// assumes eoi_pkg and the terminal model; drains words on the system side.
`timescale 1ns/1ps
module e3_tx_overhead_insert_port_tb;
	localparam logic [55:0] DEF = 56'hA5C30F963C5A71;
	localparam logic [55:0] ACC = 56'h000000FFFFFFFF;
	logic sys_clk_i, nrst_i, line_clk, bclk, bnd, ins_en, ins_d;
	logic rdy, ovr, vld, syn, len_chk;
	logic [5:0] cnt, len;
	logic [55:0] mask, val;
	eoi_pkg::eoi_ovh_word_type word;
	int err_count, n_tests, r, n;
	// plan rows: mask and value, bit 55 is position 0
	logic [55:0] rm [5] = '{56'h0, {56{1'b1}}, {56{1'b1}},
		56'h000000FC000000, 56'hFFFFFF00000000};
	logic [55:0] rv [5] = '{{56{1'b1}}, {56{1'b1}}, ~DEF,
		56'h000000A8000000, ~DEF};

	// design and terminal side
	eoi_tx_ovh_port #(.DEFAULT_OVH(DEF), .FIFO_DEPTH(32)) dut_u (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ovh_line_clk_i(line_clk),
		.ovh_bit_clock_o(bclk), .ovh_frame_boundary_o(bnd),
		.ovh_insert_enable_i(ins_en), .ovh_data_in_i(ins_d),
		.ovh_word_o(word), .ovh_word_valid_o(vld),
		.ovh_word_ready_i(rdy), .ovh_overrun_o(ovr));
	eoi_term_model term_u (.bit_clk_i(bclk), .boundary_i(bnd),
		.ins_en_o(ins_en), .ins_data_o(ins_d), .mask_i(mask), .val_i(val),
		.cnt_o(cnt), .len_o(len), .synced_o(syn));

	// system clock and unrelated link clock
	initial
	begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	initial
	begin
		line_clk = 1'b0;
		#7;
		forever #16 line_clk = ~line_clk;
	end

	task automatic check(input logic [18:0] got, input logic [18:0] want);
		n_tests++;
		if (got !== want)
		begin
			err_count++;
			$display("unexpected at %0t: got %0h want %0h", $time, got, want);
		end
	endtask

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// take one word at the edge where it pops
	task automatic get_word(output eoi_pkg::eoi_ovh_word_type w);
		int t = 0;
		do
		begin
			@(posedge sys_clk_i);
			t++;
		end
		while (vld !== 1'b1 && t < 2000);
		w = word;
	endtask

	// align to byte 0, then compare one whole frame
	task automatic frame(input logic [55:0] m, v, input bit chk);
		eoi_pkg::eoi_ovh_word_type w, e;
		logic [55:0] am, d;
		am = m & ACC;
		d = (DEF & ~am) | (v & am);
		do
			get_word(w);
		while (w.byte_idx !== 3'h0);
		for (int k = 0; k < 7; k++)
		begin
			if (k > 0)
				get_word(w);
			e.byte_idx = k[2:0];
			e.data = d[55 - 8 * k -: 8];
			e.ins_mask = am[55 - 8 * k -: 8];
			if (chk)
				check(w, e);
		end
	endtask

	// frame length seen by the terminal side
	always @(negedge bclk)
		if (len_chk && syn && cnt === 6'h00)
			check({13'h0, len}, 19'h00037);

	// watchdog
	initial
	begin
		repeat (40000) @(posedge sys_clk_i);
		err_count++;
		finish_test();
	end

	// main sequence
	initial
	begin
		err_count = 0;
		n_tests = 0;
		nrst_i = 1'b0;
		rdy = 1'b0;
		len_chk = 1'b1;
		mask = 56'h0;
		val = 56'h0;
		repeat (10) @(posedge sys_clk_i);
		check({15'h0, bclk, bnd, vld, ovr}, 19'h0);
		repeat (2) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		rdy <= 1'b1;
		$display("reset test done");
		// planned rows: one frame to settle, one frame compared
		for (r = 0; r < 5; r++)
		begin
			mask <= rm[r];
			val <= rv[r];
			frame(rm[r], rv[r], 1'b0);
			frame(rm[r], rv[r], 1'b1);
			$display("row %0d done", r);
		end
		check({18'h0, ovr}, 19'h0);
		// stall the drain until the buffer is full, then empty it
		@(posedge sys_clk_i);
		rdy <= 1'b0;
		repeat (3600) @(posedge sys_clk_i);
		check({17'h0, vld, ovr}, 19'h3);
		rdy <= 1'b1;
		n = 0;
		@(posedge sys_clk_i);
		while (vld === 1'b1 && n < 100)
		begin
			n++;
			@(posedge sys_clk_i);
		end
		check({18'h0, n >= 32}, 19'h1);
		$display("fill test done");
		// reset in mid-run, then insertion again
		len_chk <= 1'b0;
		nrst_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		check({15'h0, bclk, bnd, vld, ovr}, 19'h0);
		nrst_i <= 1'b1;
		mask <= rm[2];
		val <= rv[2];
		frame(rm[2], rv[2], 1'b0);
		frame(rm[2], rv[2], 1'b1);
		$display("second reset test done");
		finish_test();
	end
endmodule
